// >>> src/qwsc_ctrl.sv
// Serial frame receiver, wiper registers and store sequencer, four channels.
// Operation
// - Frame: start bit, two address, eight data.
// - Serial input sampled on link rising edge.
// - Channel output updates right after last data bit.
// - Receiver ready again two cycles after frame.
// - Store sequenced internally on link edges; host must keep link clock running.
// - Each frame shifts previous setting out serially, zeros if the snapshot is not stable.
// - Readback is destructive; zeros replace shifted-out bits.
// - Early chip select drop reloads stored value.
// - Temporary writes allowed any channel, except while storing.
// - Chip select low restores all stored settings.
// - Unstored frame discarded two cycles after reception.
// - Bits travel LSB first after a one start bit.
// - While storing: flag low, input ignored, output off.
// - Low supply keeps flag high, store not recorded.
// - Address A0 first, A1 second selects channel.
`timescale 1ns/1ns
module qwsc_ctrl
	import qwsc_pkg::*;
#(
	parameter int unsigned NV_CYCLES = NV_CYCLES_DEF
) (
	// System clock, synchronous reset and clock enable.
	input  wire logic                          clk,
	input  wire logic                          reset,
	input  wire logic                          ce,
	// Serial link, all timed by the link clock.
	input  wire logic                          link_clk,
	input  wire logic                          chip_select,
	input  wire logic                          serial_in,
	input  wire logic                          store_request,
	output logic                               serial_out,
	output logic                               serial_out_oe,
	output logic                               nv_cycle_flag,
	// Supply monitor: high when programming voltage is sufficient.
	input  wire logic                          supply_ok,
	// Wiper settings that drive the four outputs.
	output logic [NCHAN-1:0][DATA_W-1:0]       wiper_channel
);

	localparam int NVC_W = $clog2(NV_CYCLES + 1);

	// Link domain state.
	logic                lrst;          // Reset seen in the link domain.
	logic                supply_l;      // Supply monitor in the link domain.
	logic                stable_l;      // Wiper snapshot may be read.
	qwsc_lstate_t        lstate_ff;     // Receiver state.
	qwsc_lstate_t        nxt_lstate;
	logic [2:0]          cnt_ff;        // Bit counter within a phase.
	logic [2:0]          nxt_cnt;
	logic [CHAN_W-1:0]   addr_sh_ff;    // Address bits as they arrive.
	logic [CHAN_W-1:0]   nxt_addr_sh;
	logic [DATA_W-1:0]   data_sh_ff;    // Data bits as they arrive.
	logic [DATA_W-1:0]   nxt_data_sh;
	logic [DATA_W-1:0]   dout_sh_ff;    // Previous setting being shifted out.
	logic [DATA_W-1:0]   nxt_dout_sh;
	logic [CHAN_W-1:0]   frm_addr_ff;   // Completed frame, held for crossing.
	logic [CHAN_W-1:0]   nxt_frm_addr;
	logic [DATA_W-1:0]   frm_data_ff;
	logic [DATA_W-1:0]   nxt_frm_data;
	logic                frm_tgl_ff;    // Flips once per completed frame.
	logic                nxt_frm_tgl;
	logic                store_request_valid_ff; // Frame still eligible for a store.
	logic                nxt_store_request_valid;
	logic                ready_ff;      // Low during an erase/write cycle.
	logic                nxt_ready;
	logic [NVC_W-1:0]    nv_cnt_ff;     // Link cycles left in the store.
	logic [NVC_W-1:0]    nxt_nv_cnt;
	logic                done_tgl_ff;   // Flips when a store completes.
	logic                nxt_done_tgl;

	// System domain state.
	logic                cs_s;          // Chip select in the system domain.
	logic                frm_tgl_s;     // Frame toggle, synchronised.
	logic                done_tgl_s;    // Store toggle, synchronised.
	logic                frm_seen_ff;   // Last frame toggle acted upon.
	logic                nxt_frm_seen;
	logic                done_seen_ff;  // Last store toggle acted upon.
	logic                nxt_done_seen;
	logic                stable_ff;     // Wipers not changing this cycle.
	logic                nxt_stable;
	logic [NCHAN-1:0][DATA_W-1:0] wiper_ff;  // Volatile wiper registers.
	logic [NCHAN-1:0][DATA_W-1:0] nxt_wiper;
	logic [NCHAN-1:0][DATA_W-1:0] nv_ff;     // Stored settings.
	logic [NCHAN-1:0][DATA_W-1:0] nxt_nv;
	logic                frm_edge;      // A new frame has crossed over.
	logic                done_edge;     // A store has completed.

	// Synchronisers into the link domain; they only advance on link edges.
	qwsc_sync #(.WIDTH(3)) u_sync_link (
		.clk (link_clk),
		.en  (1'b1),
		.d   ({reset, supply_ok, stable_ff}),
		.q   ({lrst, supply_l, stable_l})
	);

	// Synchronisers into the system domain, frozen with the clock enable.
	qwsc_sync #(.WIDTH(3)) u_sync_sys (
		.clk (clk),
		.en  (ce),
		.d   ({chip_select, frm_tgl_ff, done_tgl_ff}),
		.q   ({cs_s, frm_tgl_s, done_tgl_s})
	);

	// Link receiver. Chip select, data and store request come from the
	// party that makes the link clock, so they are sampled directly.
	// A partial frame is dropped at the first link edge with chip select
	// low; the host must give one such edge after an aborted frame.
	always_comb begin
		nxt_lstate     = lstate_ff;
		nxt_cnt        = cnt_ff;
		nxt_addr_sh    = addr_sh_ff;
		nxt_data_sh    = data_sh_ff;
		nxt_dout_sh    = dout_sh_ff;
		nxt_frm_addr   = frm_addr_ff;
		nxt_frm_data   = frm_data_ff;
		nxt_frm_tgl    = frm_tgl_ff;
		nxt_store_request_valid = store_request_valid_ff;
		nxt_ready      = ready_ff;
		nxt_nv_cnt     = nv_cnt_ff;
		nxt_done_tgl   = done_tgl_ff;
		if (lrst) begin
			nxt_lstate     = L_IDLE;
			nxt_cnt        = 3'h0;
			nxt_dout_sh    = '0;
			nxt_store_request_valid = 1'b0;
			nxt_ready      = 1'b1;
			nxt_nv_cnt     = '0;
			nxt_frm_tgl    = 1'b0;
			nxt_done_tgl   = 1'b0;
		end else if (lstate_ff == L_BUSY) begin
			// The store runs on link edges; input is ignored.
			if (nv_cnt_ff <= NVC_W'(1)) begin
				// Hand the committed word over to the cells.
				nxt_done_tgl   = ~done_tgl_ff;
				nxt_ready      = 1'b1;
				nxt_store_request_valid = 1'b0;
				nxt_lstate     = L_IDLE;
				nxt_nv_cnt     = '0;
			end else begin
				nxt_nv_cnt = nv_cnt_ff - NVC_W'(1);
			end
		end else if (!chip_select) begin
			// Any partial frame is discarded.
			nxt_lstate     = L_IDLE;
			nxt_cnt        = 3'h0;
			nxt_store_request_valid = 1'b0;
		end else begin
			case (lstate_ff)
				L_IDLE: begin
					// A one is the start bit.
					if (serial_in) begin
						nxt_lstate = L_ADDR;
						nxt_cnt    = 3'h0;
					end
				end
				L_ADDR: begin
					// First address bit is the low one.
					nxt_addr_sh[cnt_ff[0]] = serial_in;
					nxt_cnt                = cnt_ff + 3'h1;
					if (cnt_ff == ADDR_LAST) begin
						nxt_lstate = L_DATA;
						nxt_cnt    = 3'h0;
						// Load the setting being replaced.
						nxt_dout_sh = stable_l ?
							wiper_ff[{serial_in, addr_sh_ff[0]}] : '0;
					end
				end
				L_DATA: begin
					// Data arrives LSB first.
					nxt_data_sh[cnt_ff] = serial_in;
					// Old bits leave as new ones come.
					nxt_dout_sh = {1'b0, dout_sh_ff[DATA_W-1:1]};
					nxt_cnt     = cnt_ff + 3'h1;
					if (cnt_ff == DATA_LAST) begin
						// Hand the frame to the wipers.
						nxt_frm_addr   = addr_sh_ff;
						nxt_frm_data   = {serial_in, data_sh_ff[6:0]};
						nxt_frm_tgl    = ~frm_tgl_ff;
						nxt_store_request_valid = 1'b1;
						nxt_lstate     = L_GAP;
						nxt_cnt        = 3'h0;
					end
				end
				L_GAP: begin
					nxt_cnt = cnt_ff + 3'h1;
					// Store request taken at the first gap edge.
					if (cnt_ff == 3'h0 && store_request && store_request_valid_ff) begin
						if (supply_l) begin
							// Flag drops for the cycle.
							nxt_ready  = 1'b0;
							nxt_nv_cnt = NVC_W'(NV_CYCLES);
							nxt_lstate = L_BUSY;
						end else begin
							// Flag stays high; nothing stored.
							nxt_store_request_valid = 1'b0;
						end
					end else if (cnt_ff == GAP_LAST) begin
						// Unstored frame dropped.
						nxt_store_request_valid = 1'b0;
						nxt_lstate     = L_IDLE;
						nxt_cnt        = 3'h0;
					end
				end
				default: begin
					nxt_lstate = L_IDLE;
					nxt_cnt    = 3'h0;
				end
			endcase
		end
	end

	// Link domain registers.
	always_ff @(posedge link_clk) begin
		lstate_ff     <= nxt_lstate;
		cnt_ff        <= nxt_cnt;
		addr_sh_ff    <= nxt_addr_sh;
		data_sh_ff    <= nxt_data_sh;
		dout_sh_ff    <= nxt_dout_sh;
		frm_addr_ff   <= nxt_frm_addr;
		frm_data_ff   <= nxt_frm_data;
		frm_tgl_ff    <= nxt_frm_tgl;
		store_request_valid_ff <= nxt_store_request_valid;
		ready_ff      <= nxt_ready;
		nv_cnt_ff     <= nxt_nv_cnt;
		done_tgl_ff   <= nxt_done_tgl;
	end

	// Output is off with chip select low and while storing.
	assign serial_out    = dout_sh_ff[0];
	assign serial_out_oe = chip_select & ready_ff;
	assign nv_cycle_flag = ready_ff;
	// Frame and store words are held still until the toggle is seen here.
	assign frm_edge  = frm_tgl_s ^ frm_seen_ff;
	assign done_edge = done_tgl_s ^ done_seen_ff;
	// Wiper and stored-setting update in the system domain.
	always_comb begin
		nxt_frm_seen  = frm_tgl_s;
		nxt_done_seen = done_tgl_s;
		nxt_wiper     = wiper_ff;
		nxt_nv        = nv_ff;
		// The snapshot is only offered while nothing is about to change.
		nxt_stable    = cs_s & ~frm_edge;
		if (done_edge) begin
			nxt_nv[frm_addr_ff] = frm_data_ff;
		end
		if (!cs_s) begin
			// Stored settings return.
			nxt_wiper = nv_ff;
		end else if (frm_edge) begin
			// Temporary write to any channel.
			nxt_wiper[frm_addr_ff] = frm_data_ff;
		end
	end

	// System registers; reset loads NV_INIT into wipers and stored settings, ce freezes the rest.
	always_ff @(posedge clk) begin
		if (reset) begin
			frm_seen_ff  <= frm_tgl_s;
			done_seen_ff <= done_tgl_s;
			stable_ff    <= 1'b0;
			wiper_ff     <= {NCHAN{NV_INIT}};
			nv_ff        <= {NCHAN{NV_INIT}};
		end else if (ce) begin
			frm_seen_ff  <= nxt_frm_seen;
			done_seen_ff <= nxt_done_seen;
			stable_ff    <= nxt_stable;
			wiper_ff     <= nxt_wiper;
			nv_ff        <= nxt_nv;
		end
	end

	assign wiper_channel = wiper_ff;
	// Last data bit taken while selected and out of reset.
	sequence seq_last_bit;
		lstate_ff == L_DATA && cnt_ff == DATA_LAST && chip_select && !lrst;
	endsequence

	// First gap edge selected with no store request, then one more edge.
	sequence seq_gap_two;
		(lstate_ff == L_GAP && cnt_ff == 3'h0 && chip_select
		&& !store_request) ##1 !lrst;
	endsequence

	AST_GAP_TWO: assert property (
		@(posedge link_clk) disable iff (lrst)
		seq_last_bit ##1 seq_gap_two |=> lstate_ff == L_IDLE)
		else $error("Receiver not idle two cycles after a frame.");
	AST_START_BIT: assert property (
		@(posedge link_clk) disable iff (lrst)
		lstate_ff == L_IDLE && chip_select && serial_in
		|=> lstate_ff == L_ADDR && cnt_ff == 3'h0)
		else $error("Start bit did not open a frame.");
	AST_CS_DROP: assert property (
		@(posedge link_clk) disable iff (lrst)
		!chip_select && lstate_ff != L_BUSY |=> lstate_ff == L_IDLE)
		else $error("Partial frame survived a chip select drop.");
	AST_STORE_BUSY: assert property (
		@(posedge link_clk) disable iff (lrst)
		lstate_ff == L_GAP && cnt_ff == 3'h0 && chip_select
		&& store_request && store_request_valid_ff && supply_l
		|=> !nv_cycle_flag && !serial_out_oe)
		else $error("Store request did not start a busy cycle.");
	AST_LOW_SUPPLY: assert property (
		@(posedge link_clk) disable iff (lrst)
		lstate_ff == L_GAP && cnt_ff == 3'h0 && chip_select
		&& store_request && !supply_l
		|=> nv_cycle_flag && !store_request_valid_ff)
		else $error("Store went ahead with low supply.");
	AST_READBACK: assert property (
		@(posedge link_clk) disable iff (lrst)
		lstate_ff == L_ADDR && cnt_ff == ADDR_LAST && chip_select
		&& stable_l
		|=> dout_sh_ff == $past(wiper_ff[{serial_in, addr_sh_ff[0]}]))
		else $error("Readback did not load the replaced setting.");
	AST_DESTRUCT: assert property (
		@(posedge link_clk) disable iff (lrst)
		lstate_ff == L_DATA && chip_select
		|=> dout_sh_ff[DATA_W-1] == 1'b0)
		else $error("Shifted-out bit was not replaced.");
	AST_FRAME_COMMIT: assert property (
		@(posedge clk) disable iff (reset)
		ce && cs_s && frm_edge |=> wiper_channel[$past(frm_addr_ff)]
		== $past(frm_data_ff))
		else $error("Frame did not reach the wiper.");
	AST_CS_RELOAD: assert property (
		@(posedge clk) disable iff (reset)
		ce && !cs_s && !done_edge |=> wiper_channel == $past(nv_ff))
		else $error("Stored settings not restored on deselect.");
	AST_NV_WRITE: assert property (
		@(posedge clk) disable iff (reset)
		ce && done_edge |=> nv_ff[$past(frm_addr_ff)] == $past(frm_data_ff))
		else $error("Completed store not written to the cells.");

endmodule

// >>> src/qwsc_pkg.sv
// Shared constants and types for the quad wiper serial store controller.
package qwsc_pkg;

	// Width of one wiper setting in bits.
	localparam int DATA_W = 8;
	// Width of the channel address in bits.
	localparam int CHAN_W = 2;
	// Number of wiper channels.
	localparam int NCHAN = 4;

	// Bit counter value of the last address bit (two address bits).
	localparam logic [2:0] ADDR_LAST = 3'h1;
	// Bit counter value of the last data bit (eight data bits).
	localparam logic [2:0] DATA_LAST = 3'h7;
	// Bit counter value of the last gap cycle (two cycles after a frame).
	localparam logic [2:0] GAP_LAST = 3'h1;

	// Longest erase/write cycle in milliseconds.
	localparam int T_BUSY_MS = 5;
	// Highest link clock rate in kilohertz.
	localparam int LINK_FMAX_KHZ = 1000;
	// Link clock cycles that cover the erase/write cycle at the top rate.
	localparam int NV_CYCLES_DEF = T_BUSY_MS * LINK_FMAX_KHZ;

	// Setting that the stored cells hold after power-up.
	localparam logic [DATA_W-1:0] NV_INIT = 8'h80;

	// States of the link-side frame receiver.
	typedef enum logic [2:0] {
		L_IDLE = 3'h0,
		L_ADDR = 3'h1,
		L_DATA = 3'h2,
		L_GAP  = 3'h3,
		L_BUSY = 3'h4
	} qwsc_lstate_t;

endpackage

// >>> src/qwsc_sync.sv
// Two-stage synchroniser for levels and toggles entering a clock domain.
`timescale 1ns/1ns
module qwsc_sync #(
	parameter int WIDTH = 1
) (
	// Destination clock and stall.
	input  wire logic             clk,
	input  wire logic             en,
	// Signal from the other domain and its synchronised copy.
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_ff;     // First stage, read only by the second.
	logic [WIDTH-1:0] sync_ff;     // Second stage, safe for logic.
	logic [WIDTH-1:0] nxt_meta;    // Next first stage.
	logic [WIDTH-1:0] nxt_sync;    // Next second stage.

	// Both stages hold while the stall is active so nothing is skipped.
	always_comb begin
		nxt_meta = meta_ff;
		nxt_sync = sync_ff;
		if (en) begin
			nxt_meta = d;
			nxt_sync = meta_ff;
		end
	end

	// Plain registers; no reset, so a stray level settles in two edges.
	always_ff @(posedge clk) begin
		meta_ff <= nxt_meta;
		sync_ff <= nxt_sync;
	end

	assign q = sync_ff;

endmodule

// >>> testbench/qwsc_host.sv
// Host model that clocks serial frames into the wiper controller.
`timescale 1ns/1ns
module qwsc_host #(
	parameter int BUSY_MAX = 64
) (
	// Serial link driven by the host.
	output logic      link_clk,
	output logic      chip_select,
	output logic      serial_in,
	output logic      store_request,
	// Answers from the controller.
	input  wire logic serial_out,
	input  wire logic serial_out_oe,
	input  wire logic nv_cycle_flag
);
	logic oe_seen; // Output enable seen during a store.

	// The link clock stands still low until a task runs it.
	initial begin
		link_clk = 1'b0;
		chip_select = 1'b0;
		serial_in = 1'b0;
		store_request = 1'b0;
		oe_seen = 1'b0;
	end

	// One link cycle; serial_out is read just before the rising edge.
	// Uneven halves keep rising link edges off the system clock's edges.
	// A released line reads back inverted so a stale bit cannot pass.
	task automatic pulse(input logic d, output logic so);
		serial_in = d;
		#77;
		so = serial_out_oe ? serial_out : ~serial_out;
		link_clk = 1'b1;
		#83;
		link_clk = 1'b0;
	endtask

	// Idle cycles; a deselected line toggles so a stale value cannot pass.
	task automatic idle(input int n);
		logic so;
		repeat (n) begin
			pulse(chip_select ? 1'b0 : ~serial_in, so);
		end
	endtask

	// Start bit, address and nbits data bits, LSB first, collecting readback.
	task automatic frame(input logic [1:0] addr, input logic [7:0] data,
		input int nbits, input logic store, output logic [7:0] rd);
		logic so;
		rd = 8'h00;
		pulse(1'b1, so);
		store_request = store;
		pulse(addr[0], so);
		pulse(addr[1], so);
		for (int i = 0; i < nbits; i++) begin
			pulse(data[i], so);
			rd[i] = so;
		end
	endtask

	// Gap cycles after a frame; the clock keeps running while storing.
	task automatic gap(output int n);
		logic so;
		n = 0;
		oe_seen = 1'b0;
		pulse(1'b0, so);
		store_request = 1'b0;
		while (nv_cycle_flag !== 1'b1 && n < BUSY_MAX) begin
			oe_seen = oe_seen | serial_out_oe;
			// Junk bits that a busy device must ignore.
			pulse(~n[0], so);
			n++;
		end
		pulse(1'b0, so);
	endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the quad wiper serial store controller.
`timescale 1ns/1ns
module testbench;
	import qwsc_pkg::*;

	localparam int NVC = 8; // Shortened store length.

	// One temporary write and what it should give.
	typedef struct {
		logic [1:0] addr;
		logic [7:0] data;
		int         idx;
		logic [7:0] rd;
	} qwsc_row_t;

	logic                         clk;
	logic                         reset;
	logic                         ce;
	logic                         supply_ok;
	logic                         link_clk;
	logic                         chip_select;
	logic                         serial_in;
	logic                         store_request;
	logic                         serial_out;
	logic                         serial_out_oe;
	logic                         nv_cycle_flag;
	logic [NCHAN-1:0][DATA_W-1:0] wiper_channel;
	logic [7:0]                   exp_w [NCHAN]; // Expected wipers.
	logic [7:0]                   st [NCHAN];    // Expected stored cells.
	logic [7:0]                   rd;
	int                           n;
	int                           errors;
	int                           checked;
	qwsc_row_t                    rows [5];

	qwsc_ctrl #(.NV_CYCLES(NVC)) DUT (
		.clk(clk), .reset(reset), .ce(ce), .link_clk(link_clk),
		.chip_select(chip_select), .serial_in(serial_in),
		.store_request(store_request), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .nv_cycle_flag(nv_cycle_flag),
		.supply_ok(supply_ok), .wiper_channel(wiper_channel)
	);

	qwsc_host host (
		.link_clk(link_clk), .chip_select(chip_select),
		.serial_in(serial_in), .store_request(store_request),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe),
		.nv_cycle_flag(nv_cycle_flag)
	);

	// System clock at 100 MHz.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Compares one value and reports a mismatch at once.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	// Compares all four wipers against the expected table.
	task automatic check_all();
		for (int i = 0; i < NCHAN; i++) begin
			check(wiper_channel[i], exp_w[i]);
		end
	endtask

	// Selects the device and lets the select settle before a frame.
	task automatic open_cs();
		host.chip_select = 1'b1;
		host.idle(3);
	endtask

	// Deselects; every wiper should fall back to its stored value.
	task automatic close_cs();
		host.chip_select = 1'b0;
		host.idle(1);
		repeat (4) @(negedge clk);
		exp_w = st;
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Cuts a hang short well after the expected run time.
	initial begin
		#300000;
		errors++;
		final_report();
	end

	// Main sequence.
	initial begin
		errors = 0;
		checked = 0;
		reset = 1'b1;
		ce = 1'b1;
		supply_ok = 1'b1;
		for (int i = 0; i < NCHAN; i++) st[i] = NV_INIT;
		exp_w = st;
		rows = '{'{2'h0, 8'h11, 0, 8'h80}, '{2'h1, 8'h22, 1, 8'h80},
			'{2'h2, 8'h33, 2, 8'h80}, '{2'h3, 8'h44, 3, 8'h80},
			'{2'h0, 8'hA5, 0, 8'h11}};
		// The link domain needs its own edges while reset is high.
		repeat (6) @(negedge clk);
		host.idle(4);
		@(negedge clk);
		reset = 1'b0;
		repeat (3) @(negedge clk);
		host.idle(1);
		check_all();
		check(8'(nv_cycle_flag), 8'h01);
		check(8'(serial_out_oe), 8'h00);
		// Temporary writes to every channel, back to back.
		open_cs();
		check(8'(serial_out_oe), 8'h01);
		foreach (rows[r]) begin
			host.frame(rows[r].addr, rows[r].data, 8, 1'b0, rd);
			host.gap(n);
			check(rd, rows[r].rd);
			check(n[7:0], 8'h00);
			exp_w[rows[r].idx] = rows[r].data;
			check_all();
		end
		close_cs();
		check_all();
		// Stored write with busy junk on the input.
		open_cs();
		host.frame(2'h2, 8'h5A, 8, 1'b1, rd);
		host.gap(n);
		check(rd, 8'h80);
		check(n[7:0], 8'(NVC));
		check(8'(host.oe_seen), 8'h00);
		st[2] = 8'h5A;
		exp_w[2] = 8'h5A;
		check_all();
		close_cs();
		check_all();
		// Store refused on a weak supply.
		supply_ok = 1'b0;
		open_cs();
		host.frame(2'h2, 8'hC3, 8, 1'b1, rd);
		host.gap(n);
		check(rd, 8'h5A);
		check(n[7:0], 8'h00);
		close_cs();
		check_all();
		supply_ok = 1'b1;
		// Readback frame cut short before the twelfth cycle.
		open_cs();
		host.frame(2'h2, 8'h00, 8, 1'b0, rd);
		check(rd, 8'h5A);
		close_cs();
		check_all();
		// Frame aborted mid-data, then a clean frame.
		open_cs();
		host.frame(2'h0, 8'hFF, 3, 1'b0, rd);
		close_cs();
		open_cs();
		host.frame(2'h0, 8'h3C, 8, 1'b0, rd);
		host.gap(n);
		check(rd, 8'h80);
		exp_w[0] = 8'h3C;
		check_all();
		// A low enable holds the wipers through a deselect.
		ce = 1'b0;
		close_cs();
		exp_w[0] = 8'h3C;
		check_all();
		// Once enabled again, the deselect takes effect.
		ce = 1'b1;
		repeat (4) @(negedge clk);
		exp_w = st;
		check_all();
		final_report();
	end
endmodule
